/* hw/adc_control_top.sv */
// control, timing and register logic of the 10-bit sar converter
//
// Notes on behaviour
// [R1] 10-bit unsigned result by successive approximation after a sample-and-hold phase.
// [R2] result bits 9:8 in upper result register bits 1:0, bits 7:0 lower.
// [R3] reference field bits 7:5 upper control: 000 off, 001 2.5V, 010 1.5V, 100 750mV.
// [R4] reference resets to the 2.5 V code.
// [R5] channel codes 1 to 8 pick io pins 0 to 7, sampled 3 us.
// [R6] code 9 picks the supply, sampled 10 us, path off in standby.
// [R7] code 10 picks the current reference pin, sampled 3 us.
// [R8] writing start bit 0 of lower control launches a conversion.
// [R9] fast bit 1 clear gives 10 us conversion, set gives 5 us.
// [R10] busy flag bit 7 of lower control reads high during conversion.
// [R11] end of conversion raises interrupt request with a programmable priority.
// [R12] busy rises next cycle, result loads before busy falls, start self-clears.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module adc_control_top
   import adc_ctl_pkg::*;
   #(parameter int BITS = RESULT_BITS)
   (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_ADDR_W-1:0] PADDR,
   input wire logic [APB_DATA_W-1:0] PWDATA,
   output logic [APB_DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic COMPARATOR_IN,
   input wire logic STANDBY_IN,
   output analog_ctl_s ANALOG_CTL,
   output logic CONVERSION_DONE_IRQ,
   output logic [1:0] IRQ_PRIORITY
   );

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   conv_state_e state_q;
   conv_state_e state_d;
   logic pready_q;
   logic pslverr_q;
   logic [APB_DATA_W-1:0] prdata_q;
   logic [APB_DATA_W-1:0] read_word;
   logic setup;
   logic access;
   logic wr_en;
   logic [15:0] idx;
   logic start_q;
   logic fast_q;
   logic busy_q;
   logic [2:0] vref_q;
   logic [3:0] chan_q;
   logic [BITS-1:0] result_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic [1:0] prio_q;
   logic irq_q;
   logic [CNT_W-1:0] sample_cnt_q;
   logic start_go;
   logic start_refused;
   logic cmp_meta_q;
   logic cmp_q;
   logic stby_meta_q;
   logic stby_q;
   logic bit_tick;
   logic sar_done;
   logic [BITS-1:0] sar_code;
   logic [CNT_W-1:0] bit_period;
   analog_ctl_s analog_q;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // word index of a bus address; only aligned addresses are mapped
   function automatic logic is_mapped(input logic [APB_ADDR_W-1:0] addr);
      logic [15:0] i;
      i = addr[APB_ADDR_W-1:2];
      return (addr[1:0] == 2'h0) && (i >= IDX_CTL_LOW) && (i <= IDX_IRQ_PRIO);
   endfunction

   // sampling window in cycles for a given channel code
   function automatic logic [CNT_W-1:0] sample_cycles(input logic [3:0] ch);
      if (ch == CH_SUPPLY)
         return CNT_W'(SAMPLE_LONG_CYC); // [R6]
      else
         return CNT_W'(SAMPLE_SHORT_CYC); // [R5] [R7]
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // comparator and standby come from the analogue side, two flops each
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cmp_meta_q <= 1'b0;
         cmp_q <= 1'b0;
         stby_meta_q <= 1'b0;
         stby_q <= 1'b0;
      end
      else
      begin
         cmp_meta_q <= COMPARATOR_IN;
         cmp_q <= cmp_meta_q;
         stby_meta_q <= STANDBY_IN;
         stby_q <= stby_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // apb slave: zero wait states, answer registered at setup
   // ----------------------------------------------------------------
   assign idx = PADDR[APB_ADDR_W-1:2];
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE && pready_q;
   assign wr_en = access && PWRITE && is_mapped(PADDR);

   // read mux; reserved bits read as zero
   always_comb
   begin
      read_word = '0;
      unique case (idx)
         IDX_CTL_LOW:
         begin
            read_word[CTL_START_BIT] = start_q;
            read_word[CTL_FAST_BIT] = fast_q;
            read_word[CTL_BUSY_BIT] = busy_q; // [R10]
         end
         IDX_CTL_HIGH:
         begin
            read_word[VREF_LSB +: 3] = vref_q;
            read_word[CHAN_LSB +: 4] = chan_q;
         end
         IDX_RES_LOW: read_word[7:0] = result_q[7:0]; // [R2]
         IDX_RES_HIGH: read_word[1:0] = result_q[BITS-1:8]; // [R2]
         IDX_IRQ_STATUS: read_word[1:0] = irq_stat_q;
         IDX_IRQ_MASK: read_word[1:0] = irq_mask_q;
         IDX_IRQ_PRIO: read_word[1:0] = prio_q;
         default: read_word = '0;
      endcase
   end

   // data is captured in the setup cycle, so a read sees state one cycle old
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && !is_mapped(PADDR);
         if (setup && !PWRITE && is_mapped(PADDR))
            prdata_q <= read_word;
         else
            prdata_q <= '0; // read data stands only in the access cycle
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // a start while busy is dropped and flagged instead
   assign start_go = wr_en && idx == IDX_CTL_LOW && PWDATA[CTL_START_BIT] && state_q == ST_IDLE; // [R8]
   assign start_refused = wr_en && idx == IDX_CTL_LOW && PWDATA[CTL_START_BIT] && state_q != ST_IDLE;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         fast_q <= 1'b0;
         vref_q <= VREF_RESET; // [R4]
         chan_q <= CHAN_RESET;
         prio_q <= PRIO_RESET;
         irq_mask_q <= '0;
      end
      else if (wr_en)
      begin
         if (idx == IDX_CTL_LOW)
            fast_q <= PWDATA[CTL_FAST_BIT]; // [R9]
         if (idx == IDX_CTL_HIGH)
         begin
            vref_q <= PWDATA[VREF_LSB +: 3]; // [R3]
            chan_q <= PWDATA[CHAN_LSB +: 4]; // [R5]
         end
         if (idx == IDX_IRQ_MASK)
            irq_mask_q <= PWDATA[1:0];
         if (idx == IDX_IRQ_PRIO)
            prio_q <= PWDATA[1:0]; // [R11]
      end
   end

   // start reads back high for one cycle only, the first cycle of the sampling window
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         start_q <= 1'b0;
      else
         start_q <= start_go; // [R12]
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (start_go) state_d = ST_SAMPLE; // [R8]
         ST_SAMPLE: if (sample_cnt_q == '0) state_d = ST_CONVERT; // [R1]
         ST_CONVERT: if (sar_done) state_d = ST_FINISH;
         ST_FINISH: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         busy_q <= state_d != ST_IDLE; // [R10] [R12]
      end
   end

   // sampling window length follows the channel chosen at start
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         sample_cnt_q <= '0;
      else if (start_go)
         sample_cnt_q <= sample_cycles(chan_q) - CNT_W'(1); // [R5] [R6] [R7]
      else if (state_q == ST_SAMPLE && sample_cnt_q != '0)
         sample_cnt_q <= sample_cnt_q - CNT_W'(1);
   end

   // ----------------------------------------------------------------
   // bit stepping
   // ----------------------------------------------------------------
   // ten bit decisions; the fast bit halves the step period
   assign bit_period = fast_q ? CNT_W'(BIT_FAST_CYC) : CNT_W'(BIT_SLOW_CYC); // [R9]

   rate_divider #(.W(CNT_W)) u_step_div
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .enable(state_q == ST_CONVERT),
      .period(bit_period),
      .tick(bit_tick)
   );

   sar_register #(.BITS(BITS)) u_sar
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .clear(start_go),
      .step(bit_tick),
      .comp_high(cmp_q),
      .code(sar_code),
      .done(sar_done)
   );

   // result lands a cycle before busy falls
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         result_q <= '0;
      else if (state_q == ST_CONVERT && sar_done)
         result_q <= sar_code; // [R1] [R12]
   end

   // ----------------------------------------------------------------
   // analogue front end controls
   // ----------------------------------------------------------------
   // supply divider is cut in standby to save its bias current
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         analog_q <= '0;
      else
      begin
         analog_q.channel <= chan_q; // [R5] [R7]
         analog_q.reference <= vref_q; // [R3]
         analog_q.sample <= state_d == ST_SAMPLE; // [R1]
         analog_q.supply_on <= (chan_q == CH_SUPPLY) && !stby_q; // [R6]
         analog_q.dac_code <= sar_code;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask and request
   // ----------------------------------------------------------------
   always_comb
   begin
      irq_set = '0;
      irq_set[IRQ_DONE_BIT] = state_q == ST_FINISH; // [R11]
      irq_set[IRQ_OVERRUN_BIT] = start_refused;
      irq_clr = (wr_en && idx == IDX_IRQ_STATUS) ? PWDATA[1:0] : 2'h0;
   end

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         irq_stat_q <= '0;
      else
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set; // [R11]
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_stat_q & irq_mask_q); // [R11]
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign ANALOG_CTL = analog_q;
   assign CONVERSION_DONE_IRQ = irq_q;
   assign IRQ_PRIORITY = prio_q;

endmodule
`default_nettype wire

/* hw/adc_ctl_pkg.sv */
// constants, types and register map of the converter control block
package adc_ctl_pkg;

   // ----------------------------------------------------------------
   // bus and register map (index constants, byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int APB_ADDR_W = 18;
   localparam int APB_DATA_W = 32;
   localparam logic [15:0] IDX_CTL_LOW = 16'hc008;
   localparam logic [15:0] IDX_CTL_HIGH = 16'hc009;
   localparam logic [15:0] IDX_RES_LOW = 16'hc00a;
   localparam logic [15:0] IDX_RES_HIGH = 16'hc00b;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hc00c;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hc00d;
   localparam logic [15:0] IDX_IRQ_PRIO = 16'hc00e;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTL_START_BIT = 0;
   localparam int CTL_FAST_BIT = 1;
   localparam int CTL_BUSY_BIT = 7;
   localparam int VREF_LSB = 5;
   localparam int CHAN_LSB = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVERRUN_BIT = 1;
   localparam logic [2:0] VREF_OFF = 3'h0;
   localparam logic [2:0] VREF_2V5 = 3'h1;
   localparam logic [2:0] VREF_1V5 = 3'h2;
   localparam logic [2:0] VREF_0V75 = 3'h4;
   localparam logic [2:0] VREF_RESET = VREF_2V5;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [3:0] CH_SUPPLY = 4'h9;
   localparam logic [3:0] CH_CURRENT_REFERENCE_PIN = 4'ha;
   localparam logic [1:0] PRIO_RESET = 2'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int RESULT_BITS = 10;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SAMPLE_SHORT_NS = 3000;
   localparam int SAMPLE_LONG_NS = 10000;
   localparam int CONV_SLOW_NS = 10000;
   localparam int CONV_FAST_NS = 5000;
   localparam int CNT_W = 10;
   localparam int SAMPLE_SHORT_CYC = (SAMPLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_LONG_CYC = (SAMPLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_SLOW_CYC = CONV_SLOW_NS / (CLK_PERIOD_NS * RESULT_BITS);
   localparam int BIT_FAST_CYC = CONV_FAST_NS / (CLK_PERIOD_NS * RESULT_BITS);

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_SAMPLE = 4'h2,
      ST_CONVERT = 4'h4,
      ST_FINISH = 4'h8
   } conv_state_e;

   // signals towards the analogue front end
   typedef struct packed {
      logic [3:0] channel;
      logic [2:0] reference;
      logic sample;
      logic supply_on;
      logic [RESULT_BITS-1:0] dac_code;
   } analog_ctl_s;

endpackage

/* hw/rate_divider.sv */
// divider that turns the system clock into a one-cycle step enable
`timescale 1ns/1ns
`default_nettype none
module rate_divider
   #(parameter int W = 10)
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [W-1:0] period,
   output logic tick
   );

   logic [W-1:0] count_q;
   logic tick_q;

   // ----------------------------------------------------------------
   // down counter, reloaded whenever the divider is idle
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= '0;
         tick_q <= 1'b0;
      end
      else if (!enable)
      begin
         count_q <= period - W'(1);
         tick_q <= 1'b0;
      end
      else if (count_q == '0)
      begin
         count_q <= period - W'(1);
         tick_q <= 1'b1;
      end
      else
      begin
         count_q <= count_q - W'(1);
         tick_q <= 1'b0;
      end
   end

   assign tick = tick_q;

endmodule
`default_nettype wire

/* hw/sar_register.sv */
// successive approximation register, one bit decided per step
`timescale 1ns/1ns
`default_nettype none
module sar_register
   #(parameter int BITS = 10)
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic step,
   input wire logic comp_high,
   output logic [BITS-1:0] code,
   output logic done
   );

   localparam logic [BITS-1:0] TOP_BIT = {1'b1, {(BITS-1){1'b0}}};

   logic [BITS-1:0] code_q;
   logic [BITS-1:0] mask_q;
   logic done_q;

   // ----------------------------------------------------------------
   // trial bit kept while the input stays at or above the dac level
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_q <= '0;
         mask_q <= '0;
         done_q <= 1'b0;
      end
      else if (clear)
      begin
         code_q <= TOP_BIT;
         mask_q <= TOP_BIT;
         done_q <= 1'b0;
      end
      else if (step && mask_q != '0)
      begin
         code_q <= (comp_high ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
         mask_q <= mask_q >> 1;
         done_q <= mask_q[0]; // last bit just decided
      end
      else
      begin
         done_q <= 1'b0;
      end
   end

   assign code = code_q;
   assign done = done_q;

endmodule
`default_nettype wire

/* tb/adc_control_properties.sv */
// concurrent checks on the ports of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_control_properties
   import adc_ctl_pkg::*;
   (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_ADDR_W-1:0] PADDR,
   input wire logic [APB_DATA_W-1:0] PWDATA,
   input wire logic [APB_DATA_W-1:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic STANDBY_IN,
   input wire analog_ctl_s ANALOG_CTL,
   input wire logic [1:0] IRQ_PRIORITY
   );
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   logic [9:0] samp_cnt_q;
   logic [31:0] wdata_q;
   logic wr_ok;
   // a completed write, as the slave accepts it
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   // length of the sampling window; zeroed while it is closed
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         samp_cnt_q <= 10'h000;
         wdata_q <= 32'h0;
      end
      else
      begin
         samp_cnt_q <= ANALOG_CTL.sample ? samp_cnt_q + 10'h001 : 10'h000;
         if (wr_ok)
            wdata_q <= PWDATA; // kept from the last accepted write
      end
   end
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_window_end;
      ANALOG_CTL.sample ##1 !ANALOG_CTL.sample;
   endsequence
   pready_after_setup_a: assert property (s_setup |=> PREADY && PENABLE)
      else $error("no ready in the access cycle");
   slverr_read_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error response without ready or with data");
   prdata_idle_zero_a: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside an access");
   sample_window_len_a: assert property (s_window_end |-> (ANALOG_CTL.channel == CH_SUPPLY) ?
      (samp_cnt_q >= 10'd500 && samp_cnt_q <= 10'd501) : (samp_cnt_q >= 10'd150 && samp_cnt_q <= 10'd151))
      else $error("sampling window of wrong length");
   supply_off_standby_a: assert property (STANDBY_IN [*4] |-> !ANALOG_CTL.supply_on)
      else $error("supply path on in standby");
   supply_on_sel_a: assert property ((ANALOG_CTL.channel == CH_SUPPLY && !STANDBY_IN) [*5]
      |-> ANALOG_CTL.supply_on) else $error("supply path off while selected");
   ref_after_reset_a: assert property ($rose(RESET_N) |-> ##[0:1] ANALOG_CTL.reference == VREF_RESET)
      else $error("reference not at its reset code");
   // field register then front end register: the pins follow two edges after the write
   ctl_high_write_a: assert property (wr_ok && PADDR == {IDX_CTL_HIGH, 2'b00} |-> ##2
      ANALOG_CTL.channel == wdata_q[3:0] && ANALOG_CTL.reference == wdata_q[7:5])
      else $error("channel or reference not taken from write");
   prio_write_a: assert property (wr_ok && PADDR == {IDX_IRQ_PRIO, 2'b00} |=> IRQ_PRIORITY == wdata_q[1:0])
      else $error("priority not taken from write");
endmodule
bind adc_control_top adc_control_properties i_props (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .STANDBY_IN(STANDBY_IN), .ANALOG_CTL(ANALOG_CTL), .IRQ_PRIORITY(IRQ_PRIORITY));
`default_nettype wire

/* tb/adc_front_model.sv */
// behavioural analogue front end: per-channel pin levels and comparator
`timescale 1ns/1ns
`default_nettype none
module adc_front_model
   import adc_ctl_pkg::*;
   (
   input wire analog_ctl_s ctl,
   output logic comp_high
   );
   logic [9:0] level;
   // fixed level per channel; the supply path reads zero once switched off
   always_comb
   begin
      level = 10'(ctl.channel * 10'h05d + 10'h013);
      if (ctl.channel == CH_SUPPLY && !ctl.supply_on)
      begin
         level = 10'h000;
      end
      comp_high = level >= ctl.dac_code;
   end
endmodule
`default_nettype wire

/* tb/sar_adc_control_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_test
   import adc_ctl_pkg::*;
   ;
   typedef struct packed {logic [3:0] ch; logic [2:0] vref; logic fast; logic [9:0] res;} row_s;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
   logic [APB_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, comp, irq, e;
   logic [1:0] prio;
   analog_ctl_s actl;
   int num_errors = 0, samples_checked = 0;
   // expected results follow the front model's per-channel levels
   row_s rows [10] = '{'{4'h1, 3'h1, 1'b0, 10'h070}, '{4'h2, 3'h2, 1'b1, 10'h0cd}, '{4'h3, 3'h4, 1'b1, 10'h12a},
      '{4'h4, 3'h0, 1'b1, 10'h187}, '{4'h5, 3'h1, 1'b1, 10'h1e4}, '{4'h6, 3'h2, 1'b1, 10'h241},
      '{4'h7, 3'h4, 1'b1, 10'h29e}, '{4'h8, 3'h1, 1'b1, 10'h2fb}, '{4'ha, 3'h1, 1'b1, 10'h3b5},
      '{4'h0, 3'h2, 1'b1, 10'h013}};
   adc_control_top i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COMPARATOR_IN(comp),
      .STANDBY_IN(standby), .ANALOG_CTL(actl), .CONVERSION_DONE_IRQ(irq), .IRQ_PRIORITY(prio));
   adc_front_model i_front (.ctl(actl), .comp_high(comp));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic wrap_up;
      $display("checked %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; the request is held until ready is sampled high
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         num_errors++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(r, exp);
   endtask
   // start a conversion and see busy up with the start bit already gone
   task automatic start(input logic [3:0] ch, input logic [2:0] vref, input logic fast);
      apb(1'b1, IDX_CTL_HIGH, {24'h0, vref, 1'b0, ch});
      apb(1'b1, IDX_CTL_LOW, {30'h0, fast, 1'b1});
      rd_chk(IDX_CTL_LOW, {24'h0, 1'b1, 5'h0, fast, 1'b0});
   endtask
   // polling is bounded: the slow supply channel needs about 1000 cycles
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, IDX_CTL_LOW, 32'h0);
         n++;
      end
      while (r[7] !== 1'b0 && n < 600);
      if (n >= 600)
      begin
         num_errors++;
         wrap_up();
      end
   endtask
   // ----------------------------------------------------------------
   // clock and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      forever #10 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd_chk(16'(IDX_CTL_LOW + i), (i == 1) ? 32'h20 : 32'h0);
      rd_chk(16'hc00f, 32'h0);
      check({31'h0, e}, 32'h1);
      foreach (rows[i])
      begin
         start(rows[i].ch, rows[i].vref, rows[i].fast);
         wait_idle();
         rd_chk(IDX_RES_LOW, {24'h0, rows[i].res[7:0]});
         rd_chk(IDX_RES_HIGH, {30'h0, rows[i].res[9:8]});
         rd_chk(IDX_IRQ_STATUS, 32'h1);
         apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      end
      // interrupt raised when unmasked, dropped on clear, silent when masked
      apb(1'b1, IDX_IRQ_MASK, 32'h1);
      apb(1'b1, IDX_IRQ_PRIO, 32'h3);
      rd_chk(IDX_IRQ_PRIO, 32'h3);
      start(4'h3, 3'h1, 1'b1);
      wait_idle();
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, IDX_IRQ_MASK, 32'h0);
      start(4'h3, 3'h1, 1'b1);
      wait_idle();
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      // a start from idle, then a second start while busy is refused and flagged
      apb(1'b1, IDX_CTL_LOW, 32'h3);
      apb(1'b1, IDX_CTL_LOW, 32'h3);
      wait_idle();
      rd_chk(IDX_RES_LOW, 32'h2a);
      rd_chk(IDX_IRQ_STATUS, 32'h3);
      apb(1'b1, IDX_IRQ_STATUS, 32'h3);
      rd_chk(IDX_IRQ_STATUS, 32'h0);
      // supply channel: dead in standby, live otherwise, long sampling
      standby <= 1'b1;
      start(CH_SUPPLY, 3'h1, 1'b1);
      wait_idle();
      rd_chk(IDX_RES_LOW, 32'h0);
      standby <= 1'b0;
      start(CH_SUPPLY, 3'h1, 1'b0);
      wait_idle();
      rd_chk(IDX_RES_LOW, 32'h58);
      rd_chk(IDX_RES_HIGH, 32'h3);
      // busy is read-only: writing it alone starts nothing
      apb(1'b1, IDX_CTL_LOW, 32'h80);
      rd_chk(IDX_CTL_LOW, 32'h0);
      // reset in mid-conversion returns everything to reset values
      start(4'h2, 3'h2, 1'b1);
      repeat (50) @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd_chk(IDX_CTL_LOW, 32'h0);
      rd_chk(IDX_CTL_HIGH, 32'h20);
      rd_chk(IDX_IRQ_STATUS, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
